// [logic/modem_status_receiver_csr.sv]
`default_nettype none
module modem_status_receiver_csr
   import modem_status_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Processor initialization pulse
   input wire logic init_pulse,
   // Register read port
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   // Lower-half bits owned by neighbouring logic
   input wire logic modem_change_irq_enable,
   input wire logic reverse_channel_tx,
   // Receiver events
   input wire logic start_bit_centre,
   input wire logic rx_char_complete,
   // Modem leads, asynchronous
   input wire logic call_alert_signal,
   input wire logic peer_go_ahead,
   input wire logic carrier_present,
   input wire logic reverse_channel_rx,
   // Interrupt request
   output logic modem_change_irq
);
   import modem_status_pkg::*;

   // ==========================================================
   // Synchronisers; stage one is read only by stage two
   // Order: call alert, go-ahead, carrier, reverse channel
   logic [3:0] sync_first;
   logic [3:0] sync_second;
   logic [3:0] status_prev;
   logic modem_change;
   logic rx_in_progress;
   logic done_prev;
   logic [3:0] edges;
   logic change_event;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync_first <= STATUS_RESET;
         sync_second <= STATUS_RESET;
      end else begin
         sync_first <= {call_alert_signal, peer_go_ahead, carrier_present,
                        reverse_channel_rx};
         sync_second <= sync_first;
      end
   end

   // Edge history; init leaves it alone so a steady lead is not taken for a change
   always_ff @(posedge clk) begin
      if (!rstn) begin
         status_prev <= STATUS_RESET;
      end else begin
         status_prev <= sync_second;
      end
   end

   assign edges = sync_second ^ status_prev;
   // Call alert counts only on its rising edge
   assign change_event = (edges[3] & sync_second[3]) | (|edges[2:0]);

   // ==========================================================
   // Modem-change flag; a new event beats the read clear
   always_ff @(posedge clk) begin
      if (!rstn || init_pulse) begin
         modem_change <= 1'b0;
      end else if (change_event) begin
         modem_change <= 1'b1;
      end else if (reg_read) begin
         modem_change <= 1'b0;
      end
   end

   // ==========================================================
   // Receiver-active flag
   always_ff @(posedge clk) begin
      if (!rstn || init_pulse) begin
         done_prev <= 1'b0;
      end else begin
         done_prev <= rx_char_complete;
      end
   end

   // Clear wins: a start centre cannot coincide with completion in practice
   always_ff @(posedge clk) begin
      if (!rstn || init_pulse) begin
         rx_in_progress <= 1'b0;
      end else if (rx_char_complete && !done_prev) begin
         rx_in_progress <= 1'b0;
      end else if (start_bit_centre) begin
         rx_in_progress <= 1'b1;
      end
   end

   // ==========================================================
   // Read data and interrupt, both registered
   always_ff @(posedge clk) begin
      if (!rstn || init_pulse) begin
         reg_rdata <= READ_ZERO;
      end else begin
         reg_rdata <= READ_ZERO;
         reg_rdata[BIT_MODEM_CHANGE] <= modem_change;
         reg_rdata[BIT_CALL_ALERT] <= sync_second[3];
         reg_rdata[BIT_PEER_GO_AHEAD] <= sync_second[2];
         reg_rdata[BIT_CARRIER] <= sync_second[1];
         reg_rdata[BIT_RX_IN_PROGRESS] <= rx_in_progress;
         reg_rdata[BIT_REV_CHAN_RX] <= sync_second[0];
         reg_rdata[BIT_CHAR_COMPLETE] <= rx_char_complete;
         reg_rdata[BIT_IRQ_ENABLE] <= modem_change_irq_enable;
         reg_rdata[BIT_REV_CHAN_TX] <= reverse_channel_tx;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         modem_change_irq <= 1'b0;
      end else begin
         modem_change_irq <= modem_change && modem_change_irq_enable &&
                             !init_pulse;
      end
   end

   // ==========================================================
   // Checks
   // Flag and interrupt
   irq_follows_flag_a: assert property (@(posedge clk) disable iff (!rstn)
      (modem_change && modem_change_irq_enable && !init_pulse)
      |=> modem_change_irq)
      else $error("irq missing");

   irq_needs_enable_a: assert property (@(posedge clk) disable iff (!rstn)
      modem_change_irq
      |-> $past(modem_change_irq_enable))
      else $error("irq without enable");

   irq_drops_a: assert property (@(posedge clk) disable iff (!rstn)
      (!modem_change || !modem_change_irq_enable || init_pulse)
      |=> !modem_change_irq)
      else $error("irq without cause");

   edge_sets_flag_a: assert property (@(posedge clk) disable iff (!rstn)
      (change_event && !init_pulse)
      |=> modem_change)
      else $error("change lost");

   carrier_edge_sets_a: assert property (@(posedge clk) disable iff (!rstn)
      (sync_second[1] != status_prev[1] && !init_pulse)
      |=> modem_change)
      else $error("carrier change lost");

   peer_edge_sets_a: assert property (@(posedge clk) disable iff (!rstn)
      (sync_second[2] != status_prev[2] && !init_pulse)
      |=> modem_change)
      else $error("go-ahead change lost");

   reverse_edge_sets_a: assert property (@(posedge clk) disable iff (!rstn)
      (sync_second[0] != status_prev[0] && !init_pulse)
      |=> modem_change)
      else $error("reverse channel change lost");

   call_rise_sets_a: assert property (@(posedge clk) disable iff (!rstn)
      (sync_second[3] && !status_prev[3] && !init_pulse)
      |=> modem_change)
      else $error("call alert rise lost");

   ring_fall_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      (!modem_change && !init_pulse && !sync_second[3] &&
       sync_second[2:0] == status_prev[2:0]) |=> !modem_change)
      else $error("flag set without rising event");

   flag_has_cause_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(modem_change)
      |-> $past(change_event))
      else $error("flag set without event");

   read_clears_flag_a: assert property (@(posedge clk) disable iff (!rstn)
      (reg_read && !change_event)
      |=> !modem_change)
      else $error("read did not clear");

   flag_holds_a: assert property (@(posedge clk) disable iff (!rstn)
      (modem_change && !reg_read && !init_pulse)
      |=> modem_change)
      else $error("flag dropped without read");

   init_clears_all_a: assert property (@(posedge clk) disable iff (!rstn)
      init_pulse
      |=> (!modem_change && !rx_in_progress && reg_rdata == READ_ZERO))
      else $error("init did not clear");

   read_keeps_event_a: assert property (@(posedge clk) disable iff (!rstn)
      (reg_read && change_event && !init_pulse)
      |=> modem_change)
      else $error("event lost under read");

   // Synchronisers and history
   first_stage_captures_a: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> sync_first == $past({call_alert_signal, peer_go_ahead,
                                    carrier_present, reverse_channel_rx}))
      else $error("first stage stale");

   second_stage_follows_a: assert property (@(posedge clk) disable iff (!rstn)
      1'b1
      |=> sync_second == $past(sync_first))
      else $error("second stage stale");

   history_follows_a: assert property (@(posedge clk) disable iff (!rstn)
      1'b1
      |=> status_prev == $past(sync_second))
      else $error("edge history stale");

   // Receiver-active
   start_sets_active_a: assert property (@(posedge clk) disable iff (!rstn)
      (start_bit_centre && !init_pulse && !(rx_char_complete && !done_prev))
      |=> rx_in_progress)
      else $error("active not set");

   active_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      (!rx_in_progress && !start_bit_centre)
      |=> !rx_in_progress)
      else $error("active set without start");

   done_clears_active_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(rx_char_complete)
      |=> !rx_in_progress)
      else $error("active not cleared");

   active_holds_a: assert property (@(posedge clk) disable iff (!rstn)
      (rx_in_progress && !init_pulse && !(rx_char_complete && !done_prev))
      |=> rx_in_progress)
      else $error("active dropped early");

   done_history_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> done_prev == $past(rx_char_complete))
      else $error("completion history stale");

   // Register image
   flag_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_MODEM_CHANGE] == $past(modem_change))
      else $error("flag bit stale");

   call_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_CALL_ALERT] == $past(sync_second[3]))
      else $error("call alert bit stale");

   peer_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_PEER_GO_AHEAD] == $past(sync_second[2]))
      else $error("go-ahead bit stale");

   carrier_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_CARRIER] == $past(sync_second[1]))
      else $error("carrier bit stale");

   active_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_RX_IN_PROGRESS] == $past(rx_in_progress))
      else $error("active bit stale");

   reverse_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_REV_CHAN_RX] == $past(sync_second[0]))
      else $error("reverse channel bit stale");

   done_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_CHAR_COMPLETE] == $past(rx_char_complete))
      else $error("completion bit stale");

   enable_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_IRQ_ENABLE] == $past(modem_change_irq_enable))
      else $error("enable bit stale");

   tx_bit_tracks_a: assert property (@(posedge clk) disable iff (!rstn)
      !init_pulse
      |=> reg_rdata[BIT_REV_CHAN_TX] == $past(reverse_channel_tx))
      else $error("reverse transmit bit stale");

   unused_read_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      reg_rdata[9:8] == 2'b00 && reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0
      && reg_rdata[2:0] == 3'b000)
      else $error("unused bit nonzero");
endmodule : modem_status_receiver_csr
`default_nettype wire

// [common/modem_status_pkg.sv]
`default_nettype none
package modem_status_pkg;
   // ==========================================================
   // Register layout
   localparam int REG_W = 16;
   localparam int BIT_MODEM_CHANGE = 15;
   localparam int BIT_CALL_ALERT = 14;
   localparam int BIT_PEER_GO_AHEAD = 13;
   localparam int BIT_CARRIER = 12;
   localparam int BIT_RX_IN_PROGRESS = 11;
   localparam int BIT_REV_CHAN_RX = 10;
   localparam int BIT_CHAR_COMPLETE = 7;
   localparam int BIT_IRQ_ENABLE = 5;
   localparam int BIT_REV_CHAN_TX = 3;
   // ==========================================================
   // Reset values and sizes
   localparam logic [15:0] READ_ZERO = 16'h0000;
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam int SYNC_STAGES = 2;
endpackage : modem_status_pkg
`default_nettype wire

// [verification/modem_lead_model.sv]
`default_nettype none
module modem_lead_model (
   // Clock and requested lead levels
   input wire logic clk,
   input wire logic [3:0] want,
   // Lead levels seen at the block
   output logic [3:0] leads
);
   timeunit 1ns;
   timeprecision 100ps;
   // Leads move off the clock grid, so the block must synchronise them
   always @(posedge clk) leads <= #1.3 want;
endmodule : modem_lead_model
`default_nettype wire

// [verification/modem_status_receiver_csr_bench.sv]
`default_nettype none
module modem_status_receiver_csr_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import modem_status_pkg::*;
   logic clk, rstn, init_pulse, reg_read, en, tx, sbc, rcc, irq;
   logic [3:0] want, leads;
   logic [15:0] rdata, exp;
   int miscompares = 0;
   int samples_checked = 0;
   // Rows: flag expected, then call, go-ahead, carrier, reverse channel
   logic [4:0] rows [6] = '{5'h12, 5'h1a, 5'h02, 5'h16, 5'h17, 5'h16};
   modem_lead_model modem_lead_model_i (.clk(clk), .want(want), .leads(leads));
   modem_status_receiver_csr modem_status_receiver_csr_i (.clk(clk), .rstn(rstn),
      .init_pulse(init_pulse), .reg_read(reg_read), .reg_rdata(rdata),
      .modem_change_irq_enable(en), .reverse_channel_tx(tx), .start_bit_centre(sbc),
      .rx_char_complete(rcc), .call_alert_signal(leads[3]), .peer_go_ahead(leads[2]),
      .carrier_present(leads[1]), .reverse_channel_rx(leads[0]), .modem_change_irq(irq));
   task check(input string name, input logic [15:0] seen, input logic [15:0] want_v);
      samples_checked++;
      if (seen !== want_v) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, want_v, seen);
      end
   endtask : check
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task rd;
      @(posedge clk) reg_read <= 1'b1;
      @(posedge clk) reg_read <= 1'b0;
   endtask : rd
   task wrap_up;
      if (miscompares == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {rstn, init_pulse, reg_read, en, tx, sbc, rcc, want} = 11'h080;
      step(4);
      check("reset", rdata, READ_ZERO);
      @(posedge clk) rstn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) want <= rows[i][3:0];
         tx <= i[0];
         step(6);
         exp = {rows[i][4:1], 1'b0, rows[i][0], 5'h1, 1'b0, i[0], 3'h0};
         check("image", rdata, exp);
         check("irq", {15'h0, irq}, {15'h0, rows[i][4]});
         rd();
         step(3);
         check("cleared", {14'h0, rdata[15], irq}, 16'h0);
      end
      // Flag without enable must stay silent until enabled
      @(posedge clk) en <= 1'b0;
      want <= 4'h0;
      step(6);
      check("masked", {14'h0, rdata[15], irq}, 16'h2);
      @(posedge clk) en <= 1'b1;
      step(3);
      check("unmasked", {15'h0, irq}, 16'h1);
      rd();
      @(posedge clk) sbc <= 1'b1;
      @(posedge clk) sbc <= 1'b0;
      step(3);
      check("active", rdata & 16'h0880, 16'h0800);
      @(posedge clk) rcc <= 1'b1;
      step(3);
      check("done", rdata & 16'h0880, 16'h0080);
      @(posedge clk) rcc <= 1'b0;
      sbc <= 1'b1;
      @(posedge clk) sbc <= 1'b0;
      want <= 4'h2;
      step(6);
      @(posedge clk) init_pulse <= 1'b1;
      @(posedge clk) init_pulse <= 1'b0;
      step(1);
      check("init", rdata & 16'h8800, 16'h0);
      // Carrier stays up across init: no change, so no flag
      step(4);
      check("after init", {15'h0, rdata[15]}, 16'h0);
      // Carrier falls so its event lands on the edge that samples a read
      @(posedge clk) want <= 4'h0;
      repeat (2) @(posedge clk);
      @(posedge clk) reg_read <= 1'b1;
      @(posedge clk) reg_read <= 1'b0;
      step(2);
      check("coincide", {15'h0, rdata[15]}, 16'h1);
      wrap_up();
   end
endmodule : modem_status_receiver_csr_bench
`default_nettype wire
